// [verilog/phy_strap_mode_config.sv]
// strap sampling, mode decode, led polarity and carrier sense
`timescale 1ns/1ps
`default_nettype none

module phy_strap_mode_config (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire phy_strap_pkg::straps_t strapPins,
    input wire logic isolateStrap,
    input wire logic [phy_strap_pkg::LED_N-1:0] ledIn,
    output logic [phy_strap_pkg::LED_N-1:0] ledOut,
    output logic [phy_strap_pkg::LED_N-1:0] ledOe,
    input wire logic [phy_strap_pkg::LED_N-1:0] ledState,
    input wire logic advertPauseReg,
    input wire logic [phy_strap_pkg::ABILITY_W-1:0] partnerAbilityIn,
    input wire logic rxActive,
    input wire logic txActive,
    output phy_strap_pkg::mode_t mode,
    output logic advertPause,
    output logic [phy_strap_pkg::ADDR_W-1:0] mgmtAddress,
    output logic [phy_strap_pkg::ABILITY_W-1:0] partnerAbilityReg,
    output logic partnerPause,
    output logic macIsolate,
    output logic mgmtIsolate,
    output logic carrierSense,
    output logic serialTxClk,
    output logic serialRxClk,
    output logic strapsValid
);
    import phy_strap_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    straps_t strapMeta_r, strapSync_r;
    logic isoMeta_r, isoSync_r;
    logic [LED_N-1:0] ledMeta_r, ledSync_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            strapMeta_r <= STRAPS_RST;
            strapSync_r <= STRAPS_RST;
            isoMeta_r <= 1'b0;
            isoSync_r <= 1'b0;
            ledMeta_r <= ADDR_RST;
            ledSync_r <= ADDR_RST;
        end else if (ce) begin
            strapMeta_r <= strapPins;
            strapSync_r <= strapMeta_r;
            isoMeta_r <= isolateStrap;
            isoSync_r <= isoMeta_r;
            ledMeta_r <= ledIn;
            ledSync_r <= ledMeta_r;
        end
    end

    // ------------------------------------------------------------
    // strap capture and mode decode
    // ------------------------------------------------------------
    loader_st_t st_r, st_nxt;
    logic [1:0] settle_r, settle_nxt;
    mode_t mode_r, mode_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;

    always_comb begin
        st_nxt = st_r;
        settle_nxt = settle_r;
        mode_nxt = mode_r;
        addr_nxt = addr_r;
        case (st_r)
            ST_SETTLE: begin
                // wait until the synchronisers hold real strap levels
                if (settle_r == SETTLE_CYCLES) begin
                    st_nxt = ST_RUN;
                    addr_nxt = ledSync_r;
                    mode_nxt = MODE_RST;
                    mode_nxt.powerDown = (ledSync_r == ADDR_RST);
                    mode_nxt.repeaterMode = strapSync_r.repeater;
                    mode_nxt.ldpsMode = strapSync_r.link_down_power_saving;
                    if (strapSync_r.fiberSelect) begin
                        // fiber wins over interface select
                        mode_nxt.fiberMode = 1'b1;
                        mode_nxt.speed100 = 1'b1;
                        mode_nxt.fullDuplex = strapSync_r.duplex;
                    end else if (!strapSync_r.interfaceSelect) begin
                        mode_nxt.serialIface = 1'b1;
                        mode_nxt.fullDuplex = strapSync_r.duplex;
                    end else if (strapSync_r.autonegEnable) begin
                        mode_nxt.anEnable = 1'b1;
                        mode_nxt.adv10Half = 1'b1;
                        mode_nxt.adv10Full = strapSync_r.duplex;
                        mode_nxt.adv100Half = strapSync_r.speed;
                        mode_nxt.adv100Full = strapSync_r.speed & strapSync_r.duplex;
                    end else begin
                        mode_nxt.speed100 = strapSync_r.speed;
                        mode_nxt.fullDuplex = strapSync_r.duplex;
                    end
                end else begin
                    settle_nxt = settle_r + 2'h1;
                end
            end
            ST_RUN: begin
                // decode held until the next reset
                st_nxt = ST_RUN;
            end
            default: begin
                st_nxt = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= ST_SETTLE;
            settle_r <= 2'h0;
            mode_r <= MODE_RST;
            addr_r <= ADDR_RST;
        end else if (ce) begin
            st_r <= st_nxt;
            settle_r <= settle_nxt;
            mode_r <= mode_nxt;
            addr_r <= addr_nxt;
        end
    end

    // ------------------------------------------------------------
    // run-time outputs
    // ------------------------------------------------------------
    logic [LED_N-1:0] ledOut_r, ledOut_nxt;
    logic [LED_N-1:0] ledOe_r, ledOe_nxt;
    logic crs_r, crs_nxt;
    logic pause_r, pause_nxt;
    logic [ABILITY_W-1:0] partner_r, partner_nxt;
    logic [1:0] serCnt_r, serCnt_nxt;
    logic serClk_r, serClk_nxt;
    logic running;

    assign running = (st_r == ST_RUN);

    generate
        for (genvar i = 0; i < LED_N; i++) begin : g_led
            always_comb begin
                // pin stays released until its strap has been read
                ledOe_nxt[i] = (st_nxt == ST_RUN);
                ledOut_nxt[i] = ledOe_nxt[i] & (ledState[i] ^ addr_nxt[i]);
            end
        end
    endgenerate

    always_comb begin
        crs_nxt = 1'b0;
        if (running && !isoSync_r) begin
            crs_nxt = rxActive | (txActive & ~mode_r.repeaterMode);
        end
        pause_nxt = running & mode_r.anEnable & advertPauseReg;
        partner_nxt = running ? partnerAbilityIn : ABILITY_RST;
        serCnt_nxt = serCnt_r;
        serClk_nxt = 1'b0;
        if (running && mode_r.serialIface) begin
            // 40 MHz divided to a 10 MHz bit clock
            if (serCnt_r == SER_HALF_CYCLES - 2'h1) begin
                serCnt_nxt = 2'h0;
                serClk_nxt = ~serClk_r;
            end else begin
                serCnt_nxt = serCnt_r + 2'h1;
                serClk_nxt = serClk_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ledOut_r <= ADDR_RST;
            ledOe_r <= ADDR_RST;
            crs_r <= 1'b0;
            pause_r <= 1'b0;
            partner_r <= ABILITY_RST;
            serCnt_r <= 2'h0;
            serClk_r <= 1'b0;
        end else if (ce) begin
            ledOut_r <= ledOut_nxt;
            ledOe_r <= ledOe_nxt;
            crs_r <= crs_nxt;
            pause_r <= pause_nxt;
            partner_r <= partner_nxt;
            serCnt_r <= serCnt_nxt;
            serClk_r <= serClk_nxt;
        end
    end

    assign ledOut = ledOut_r;
    assign ledOe = ledOe_r;
    assign mode = mode_r;
    assign mgmtAddress = addr_r;
    assign advertPause = pause_r;
    assign partnerAbilityReg = partner_r;
    assign partnerPause = partner_r[PAUSE_BIT];
    // isolation follows the strap live, not only at reset
    assign macIsolate = isoSync_r;
    assign mgmtIsolate = isoSync_r;
    assign carrierSense = crs_r;
    assign serialTxClk = serClk_r;
    assign serialRxClk = serClk_r;
    assign strapsValid = running;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_full_advert;
        $rose(running) && $past(strapSync_r.interfaceSelect) && $past(strapSync_r.autonegEnable)
            && !$past(strapSync_r.fiberSelect) && $past(strapSync_r.speed)
            && $past(strapSync_r.duplex)
        |-> mode.anEnable && mode.adv10Half && mode.adv10Full && mode.adv100Half
            && mode.adv100Full;
    endproperty
    a_full_advert: assert property (p_full_advert) else $error("full advert missing");

    property p_no100;
        running && mode.anEnable && !mode.adv100Half |-> !mode.adv100Full;
    endproperty
    a_no100: assert property (p_no100) else $error("100 full without 100 half");

    property p_nofull;
        running && mode.anEnable && !mode.adv10Full |-> !mode.adv100Full;
    endproperty
    a_nofull: assert property (p_nofull) else $error("full duplex leaked");

    property p_forced;
        $rose(running) && !$past(strapSync_r.autonegEnable) && $past(strapSync_r.interfaceSelect)
            && !$past(strapSync_r.fiberSelect)
        |-> mode.speed100 == $past(strapSync_r.speed) && mode.fullDuplex == $past(strapSync_r.duplex)
            && !mode.anEnable;
    endproperty
    a_forced: assert property (p_forced) else $error("forced speed or duplex wrong");

    property p_serial;
        mode.serialIface |-> !mode.speed100 && !mode.anEnable && !mode.fiberMode;
    endproperty
    a_serial: assert property (p_serial) else $error("serial mode not 10 only");

    property p_serclk;
        running && mode.serialIface && $rose(serialTxClk) |-> ##2 $fell(serialTxClk);
    endproperty
    a_serclk: assert property (p_serclk) else $error("serial bit clock period wrong");

    property p_fiber;
        mode.fiberMode |-> mode.speed100 && !mode.anEnable && !mode.serialIface;
    endproperty
    a_fiber: assert property (p_fiber) else $error("fiber not 100 only");

    property p_pause;
        running && mode.anEnable && advertPauseReg |=> advertPause;
    endproperty
    a_pause: assert property (p_pause) else $error("pause not advertised");

    property p_led_pol;
        running && ledOe[0] |=> ledOut[0] == ($past(ledState[0]) ^ mgmtAddress[0]);
    endproperty
    a_led_pol: assert property (p_led_pol) else $error("led polarity wrong");

    property p_led_quiet;
        !running |-> ledOe == 5'h00;
    endproperty
    a_led_quiet: assert property (p_led_quiet) else $error("led driven before sampling");

    property p_pwd;
        running |-> mode.powerDown == (mgmtAddress == 5'h00);
    endproperty
    a_pwd: assert property (p_pwd) else $error("power down decode wrong");

    property p_crs;
        running && !isoSync_r && mode.repeaterMode && txActive && !rxActive |=> !carrierSense;
    endproperty
    a_crs: assert property (p_crs) else $error("repeater carrier on transmit");

    property p_stable;
        running && ce |=> $stable(mode) && $stable(mgmtAddress);
    endproperty
    a_stable: assert property (p_stable) else $error("decode changed between resets");

    c_serial: cover property (running && mode.serialIface && $rose(serialTxClk));
    c_fiber: cover property ($rose(running) && mode.fiberMode);
    c_autoneg: cover property ($rose(running) && mode.anEnable && !mode.adv100Half);
    c_crs_adapter: cover property (running && !mode.repeaterMode && carrierSense);

endmodule : phy_strap_mode_config

`default_nettype wire

// [verilog/phy_strap_pkg.sv]
// constants and types for the strap mode decoder
package phy_strap_pkg;

    // ------------------------------------------------------------
    // widths and positions
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int LED_N = 5;
    localparam int ABILITY_W = 16;
    localparam int PAUSE_BIT = 10;
    localparam logic [4:0] PARTNER_REG_ADDR = 5'h05;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
    localparam logic [ABILITY_W-1:0] ABILITY_RST = 16'h0000;
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;
    localparam int CORE_CLK_HZ = 40000000;
    localparam int SERIAL_BIT_HZ = 10000000;
    localparam logic [1:0] SER_HALF_CYCLES = 2'(CORE_CLK_HZ / SERIAL_BIT_HZ / 2);

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic autonegEnable;
        logic fiberSelect;
        logic interfaceSelect;
        logic speed;
        logic duplex;
        logic repeater;
        logic link_down_power_saving;
    } straps_t;

    localparam straps_t STRAPS_RST = 7'h00;

    typedef struct packed {
        logic anEnable;
        logic adv100Full;
        logic adv100Half;
        logic adv10Full;
        logic adv10Half;
        logic speed100;
        logic fullDuplex;
        logic serialIface;
        logic fiberMode;
        logic repeaterMode;
        logic ldpsMode;
        logic powerDown;
    } mode_t;

    localparam mode_t MODE_RST = 12'h000;

    typedef enum logic [0:0] {ST_SETTLE, ST_RUN} loader_st_t;

endpackage : phy_strap_pkg

// [test/strap_board_model.sv]
// board resistor model for the shared led and address pins
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
    input wire logic [phy_strap_pkg::LED_N-1:0] pullLevel,
    input wire logic [phy_strap_pkg::LED_N-1:0] ledOut,
    input wire logic [phy_strap_pkg::LED_N-1:0] ledOe,
    output logic [phy_strap_pkg::LED_N-1:0] ledPin
);
    import phy_strap_pkg::*;
    // undriven pin settles to its resistor, so the strap is read there
    always_comb begin
        for (int i = 0; i < LED_N; i++) begin
            ledPin[i] = ledOe[i] ? ledOut[i] : pullLevel[i];
        end
    end
endmodule : strap_board_model
`default_nettype wire

// [test/phy_strap_mode_config_tb.sv]
// self-checking bench for the strap mode decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module phy_strap_mode_config_tb;
    import phy_strap_pkg::*;
    logic clk, rstn, ce, isolateStrap, advertPauseReg, rxActive, txActive;
    straps_t strapPins;
    logic [LED_N-1:0] pull, ledPin, ledOut, ledOe, ledState;
    logic [ABILITY_W-1:0] partnerAbilityIn, partnerAbilityReg;
    mode_t mode, em, mask;
    logic advertPause, partnerPause, macIsolate, mgmtIsolate, carrierSense;
    logic serialTxClk, serialRxClk, strapsValid;
    logic [ADDR_W-1:0] mgmtAddress;
    logic [3:0] nTx, nRx;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    phy_strap_mode_config DUT (.clk(clk), .rstn(rstn), .ce(ce), .strapPins(strapPins),
        .isolateStrap(isolateStrap), .ledIn(ledPin), .ledOut(ledOut), .ledOe(ledOe),
        .ledState(ledState), .advertPauseReg(advertPauseReg),
        .partnerAbilityIn(partnerAbilityIn), .rxActive(rxActive), .txActive(txActive),
        .mode(mode), .advertPause(advertPause), .mgmtAddress(mgmtAddress),
        .partnerAbilityReg(partnerAbilityReg), .partnerPause(partnerPause),
        .macIsolate(macIsolate), .mgmtIsolate(mgmtIsolate), .carrierSense(carrierSense),
        .serialTxClk(serialTxClk), .serialRxClk(serialRxClk), .strapsValid(strapsValid));
    strap_board_model board (.pullLevel(pull), .ledOut(ledOut), .ledOe(ledOe),
        .ledPin(ledPin));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic mode_t exp_mode(input straps_t s, input logic [4:0] a);
        mode_t m;
        m = MODE_RST;
        m.repeaterMode = s.repeater;
        m.ldpsMode = s.link_down_power_saving;
        m.powerDown = (a == 5'h00);
        if (s.fiberSelect) begin
            m.fiberMode = 1'b1;
            m.speed100 = 1'b1;
            m.fullDuplex = s.duplex;
        end else if (!s.interfaceSelect) begin
            m.serialIface = 1'b1;
            m.fullDuplex = s.duplex;
        end else if (s.autonegEnable) begin
            m.anEnable = 1'b1;
            m.adv10Half = 1'b1;
            m.adv10Full = s.duplex;
            m.adv100Half = s.speed;
            m.adv100Full = s.speed & s.duplex;
        end else begin
            m.speed100 = s.speed;
            m.fullDuplex = s.duplex;
        end
        return m;
    endfunction : exp_mode

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // one full reset, capture and run-time pass for one strap setting
    task automatic run(input int i);
        straps_t s;
        logic [4:0] a;
        logic [ABILITY_W-1:0] pw;
        s = straps_t'(i[6:0]);
        a = 5'(i * 5 + 1);
        // partner word and pause request vary so that a tied-off path would show
        pw = {5'h00, s.duplex, 10'h1E1};
        @(posedge clk);
        rstn <= 1'b0;
        strapPins <= s;
        pull <= a;
        {isolateStrap, rxActive, txActive} <= 3'h0;
        advertPauseReg <= ~s.link_down_power_saving;
        partnerAbilityIn <= pw;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        tick(2);
        `CHK("early valid", 1'b0, strapsValid)
        for (int k = 0; k < 8 && strapsValid !== 1'b1; k++) tick(1);
        tick(1);
        em = exp_mode(s, a);
        mask = em.anEnable ? 12'hF9F : 12'hC7F;
        `CHK("mode", em & mask, mode & mask)
        `CHK("address", a, mgmtAddress)
        `CHK("led enable", 5'h1F, ledOe)
        `CHK("led pins", 5'h15 ^ a, ledPin)
        `CHK("pause advert", em.anEnable & ~s.link_down_power_saving, advertPause)
        `CHK("partner reg", pw, partnerAbilityReg)
        `CHK("partner pause", s.duplex, partnerPause)
        `CHK("isolate idle", 1'b0, macIsolate)
        @(posedge clk);
        strapPins <= ~s;
        txActive <= 1'b1;
        tick(2);
        `CHK("mode held", em & mask, mode & mask)
        `CHK("sense on tx", ~s.repeater, carrierSense)
        @(posedge clk);
        rxActive <= 1'b1;
        tick(2);
        `CHK("sense on rx", 1'b1, carrierSense)
        nTx = 4'h0;
        nRx = 4'h0;
        repeat (8) begin
            tick(1);
            nTx = nTx + 4'(serialTxClk);
            nRx = nRx + 4'(serialRxClk);
        end
        `CHK("tx bit clock", em.serialIface ? 4'h4 : 4'h0, nTx)
        `CHK("rx bit clock", em.serialIface ? 4'h4 : 4'h0, nRx)
        @(posedge clk);
        isolateStrap <= 1'b1;
        tick(3);
        `CHK("mac isolate", 1'b1, macIsolate)
        `CHK("mgmt isolate", 1'b1, mgmtIsolate)
        `CHK("sense isolated", 1'b0, carrierSense)
    endtask : run

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        strapPins = STRAPS_RST;
        pull = 5'h00;
        {isolateStrap, rxActive, txActive} = 3'h0;
        advertPauseReg = 1'b1;
        partnerAbilityIn = 16'h0400;
        ledState = 5'h15;
        for (int i = 0; i < 128; i++) run(i);
        summarize();
    end

    // each pass takes about 28 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
endmodule : phy_strap_mode_config_tb
`default_nettype wire
